/* link_pkg.sv */
// link state machine constants and state types
// assumes one 20 MHz clock and an asynchronous active-low reset
package link_pkg;

	// ----------------------------------------------------------------
	// commanded link state codes
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_NONE       = 3'h0;
	localparam logic [2:0] CMD_CONNECT    = 3'h1;
	localparam logic [2:0] CMD_RECONNECT  = 3'h2;
	localparam logic [2:0] CMD_DISCONNECT = 3'h3;
	localparam logic [2:0] CMD_ERROR      = 3'h4;

	// ----------------------------------------------------------------
	// reported actual link state codes
	// ----------------------------------------------------------------
	localparam logic [2:0] ACT_DISCONNECTED = 3'h0;
	localparam logic [2:0] ACT_CONNECTING   = 3'h1;
	localparam logic [2:0] ACT_CONNECTED    = 3'h2;
	localparam logic [2:0] ACT_PROGRAM      = 3'h3;
	localparam logic [2:0] ACT_ERROR        = 3'h4;
	localparam logic [2:0] ACT_BUSY         = 3'h7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic       FIELD_RST = 1'b0;
	localparam logic [1:0] SYNC_RST  = 2'h0;

	typedef enum logic [3:0] {
		ST_DISCONNECTED,
		ST_CONNECTING,
		ST_PRE_SESSION,
		ST_PROGRAM,
		ST_CONNECTED,
		ST_SESSION_RESTART,
		ST_SESSION_CLOSE,
		ST_STOPPING,
		ST_ERROR
	} link_state_t;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_PRETRANSMIT,
		PH_PREFETCH,
		PH_DONE
	} pre_phase_t;

endpackage : link_pkg

/* pin_sync.sv */
// two-flop synchroniser for a vector of pin-level inputs
// assumes inputs are asynchronous to CLOCK
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// data
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] out_d;

	always_comb begin
		meta_d = din;
		out_d  = meta_q;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= meta_d;
			dout   <= out_d;
		end
	end

endmodule : pin_sync

/* tag_link_props.sv */
// port assertions for the tag link state machine
// assumes a bind onto tag_link_state_machine
`timescale 1ns/1ps
module tag_link_props (
	// clock and reset
	input wire logic       CLOCK,
	input wire logic       ARST_N,
	// stimulus
	input wire logic       CMD_VALID,
	input wire logic [2:0] CMD_CODE,
	input wire logic       PRETRANSMIT_CFG,
	input wire logic       USER_PROGRAM_LOADED,
	input wire logic       LEGACY_RELEASE,
	// response
	input wire logic       RADIO_FIELD_ON,
	input wire logic       CHANNEL_CLOSE,
	input wire logic       PRETRANSMIT_RUN,
	input wire logic       PREFETCH_RUN,
	input wire logic       USER_ACTIONS_EN,
	input wire logic [2:0] ACTUAL_LINK_STATE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);
	logic [2:0] act;
	logic       c_con, c_rec, c_dis, c_err, live;
	assign act   = ACTUAL_LINK_STATE;
	assign c_con = CMD_VALID && CMD_CODE == link_pkg::CMD_CONNECT;
	assign c_rec = CMD_VALID && CMD_CODE == link_pkg::CMD_RECONNECT;
	assign c_dis = CMD_VALID && CMD_CODE == link_pkg::CMD_DISCONNECT;
	assign c_err = CMD_VALID && CMD_CODE == link_pkg::CMD_ERROR;
	assign live  = act == link_pkg::ACT_CONNECTED || act == link_pkg::ACT_PROGRAM;
	sequence s_busy_close;
		CHANNEL_CLOSE && act == link_pkg::ACT_BUSY;
	endsequence
	sequence s_stop_path;
		act == link_pkg::ACT_BUSY ##1 act == link_pkg::ACT_DISCONNECTED && !RADIO_FIELD_ON;
	endsequence
	a_connect_cmd: assert property (c_con && (act == link_pkg::ACT_DISCONNECTED ||
		act == link_pkg::ACT_ERROR) |=> act == link_pkg::ACT_CONNECTING && RADIO_FIELD_ON)
		else $error("connect command not taken");
	a_disc_hold: assert property (act == link_pkg::ACT_DISCONNECTED && !c_con |=>
		act == link_pkg::ACT_DISCONNECTED) else $error("disconnected left on its own");
	a_internal_busy: assert property (CHANNEL_CLOSE || PRETRANSMIT_RUN || PREFETCH_RUN |->
		act == link_pkg::ACT_BUSY) else $error("internal state not shown busy");
	a_field_off: assert property (act == link_pkg::ACT_DISCONNECTED |-> !RADIO_FIELD_ON)
		else $error("field on while disconnected");
	a_pre_order: assert property ($rose(PREFETCH_RUN) && PRETRANSMIT_CFG |->
		$past(PRETRANSMIT_RUN)) else $error("prefetch before pretransmit");
	a_user_gate: assert property (USER_ACTIONS_EN |-> act == link_pkg::ACT_PROGRAM &&
		USER_PROGRAM_LOADED && !LEGACY_RELEASE) else $error("user actions wrongly on");
	a_error_cmd: assert property (c_err && live |=> act == link_pkg::ACT_ERROR)
		else $error("error command not taken");
	a_dis_close: assert property (c_dis && (live || act == link_pkg::ACT_ERROR) |=>
		s_busy_close) else $error("disconnect did not close channel");
	a_stop_path: assert property (c_dis && act == link_pkg::ACT_CONNECTING |=>
		s_stop_path) else $error("stopping path wrong");
	a_restart_path: assert property (c_rec && live |=> s_busy_close ##0
		RADIO_FIELD_ON) else $error("reconnect path wrong");
endmodule : tag_link_props

bind tag_link_state_machine tag_link_props u_props (.CLOCK, .ARST_N, .CMD_VALID, .CMD_CODE,
	.PRETRANSMIT_CFG, .USER_PROGRAM_LOADED, .LEGACY_RELEASE, .RADIO_FIELD_ON, .CHANNEL_CLOSE,
	.PRETRANSMIT_RUN, .PREFETCH_RUN, .USER_ACTIONS_EN, .ACTUAL_LINK_STATE);

/* tag_link_state_machine.sv */
// link state machine of the read/write head talking to mobile data tags
// assumes tag-side events arrive asynchronously on pins; commands are used unsynchronised, as one-cycle strobes on CLOCK
//
// What this block does
// R1: state changes only by automatic condition or commanded link state
// R2: disconnected and error leave only on a commanded link state; connected and program also on automatic conditions
// R3: internal-only states report busy as actual link state
// R4: power-on enters disconnected, radio field off
// R5: connect command in disconnected or error enters connecting, field on
// R6: reconnect from connected or program enters session restart
// R7: disconnect: connecting to stopping; connected/program/error to session close
// R8: error command from connected or program enters error
// R9: connecting goes to pre-session when a tag signs on
// R10: pre-session runs pretransmits before prefetches, nothing if none configured
// R11: pre-session done without error moves to program
// R12: program moves to connected when no user program or auto mode off
// R13: legacy release: program runs only the auto mode function
// R14: session close closes channel, field off, enters disconnected
// R15: stopping stops waiting, field off, enters disconnected
// R16: session restart closes channel, field stays on, back to connecting
// R17: unexpected tag power-up in pre-session or connected returns to connecting
// R18: sign-on failure while connecting enters error
// R19: sign-off failure in restart or close enters error
// R20: tag lost while connected enters error
`timescale 1ns/1ps
module tag_link_state_machine (
	// clock and reset
	input  wire logic       CLOCK,
	input  wire logic       ARST_N,
	// commanded link state, one-cycle strobe from fieldbus side
	input  wire logic       CMD_VALID,
	input  wire logic [2:0] CMD_CODE,
	// auto mode request for reconnect
	input  wire logic       AUTO_RECONNECT,
	// configuration levels
	input  wire logic       PRETRANSMIT_CFG,
	input  wire logic       PREFETCH_CFG,
	input  wire logic       USER_PROGRAM_LOADED,
	input  wire logic       AUTO_MODE_ON,
	input  wire logic       LEGACY_RELEASE,
	// tag and radio events, pin levels
	input  wire logic       TAG_SIGNED_ON,
	input  wire logic       TAG_SIGNON_FAIL,
	input  wire logic       TAG_SIGNOFF_DONE,
	input  wire logic       TAG_SIGNOFF_FAIL,
	input  wire logic       TAG_POWER_UP,
	input  wire logic       TAG_PRESENT,
	// pre-session operation handshake and program state done
	input  wire logic       OP_DONE,
	input  wire logic       OP_FAIL,
	input  wire logic       PROGRAM_DONE,
	// outputs
	output logic            RADIO_FIELD_ON,
	output logic            CHANNEL_CLOSE,
	output logic            AWAIT_TAGS,
	output logic            PRETRANSMIT_RUN,
	output logic            PREFETCH_RUN,
	output logic            USER_ACTIONS_EN,
	output logic            AUTO_MODE_RUN,
	output logic [2:0]      ACTUAL_LINK_STATE
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync_in;

	assign raw_in = {TAG_SIGNED_ON, TAG_SIGNON_FAIL, TAG_SIGNOFF_DONE,
			TAG_SIGNOFF_FAIL, TAG_POWER_UP, TAG_PRESENT, OP_DONE, OP_FAIL,
			PROGRAM_DONE, AUTO_RECONNECT, AUTO_MODE_ON};

	pin_sync #(
		.WIDTH (NSYNC)
	) u_sync (
		.clk    (CLOCK),
		.arst_n (ARST_N),
		.din    (raw_in),
		.dout   (sync_in)
	);

	logic signed_on;
	logic signon_fail;
	logic signoff_done;
	logic signoff_fail;
	logic power_up;
	logic present;
	logic op_done;
	logic op_fail;
	logic prog_done;
	logic auto_rc;
	logic auto_on;

	assign {signed_on, signon_fail, signoff_done, signoff_fail, power_up,
		present, op_done, op_fail, prog_done, auto_rc, auto_on} = sync_in;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic cmd_connect;
	logic cmd_reconnect;
	logic cmd_disconnect;
	logic cmd_error;

	always_comb begin
		cmd_connect    = CMD_VALID && CMD_CODE == link_pkg::CMD_CONNECT;
		cmd_reconnect  = CMD_VALID && CMD_CODE == link_pkg::CMD_RECONNECT;
		cmd_disconnect = CMD_VALID && CMD_CODE == link_pkg::CMD_DISCONNECT;
		cmd_error      = CMD_VALID && CMD_CODE == link_pkg::CMD_ERROR;
	end

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	link_pkg::link_state_t state_q;
	link_pkg::link_state_t state_d;
	link_pkg::pre_phase_t  phase_q;
	link_pkg::pre_phase_t  phase_d;
	logic                  field_q;
	logic                  field_d;
	logic [2:0]            act_q;
	logic [2:0]            act_d;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		field_d = field_q;
		case (state_q)
			link_pkg::ST_DISCONNECTED: begin
				if (cmd_connect) begin
					state_d = link_pkg::ST_CONNECTING; // R5
					field_d = 1'b1; // R5
				end
			end
			link_pkg::ST_ERROR: begin
				if (cmd_connect) begin
					state_d = link_pkg::ST_CONNECTING; // R5
					field_d = 1'b1; // R5
				end else if (cmd_disconnect) begin
					state_d = link_pkg::ST_SESSION_CLOSE; // R7
				end
			end
			link_pkg::ST_CONNECTING: begin
				if (cmd_disconnect) begin
					state_d = link_pkg::ST_STOPPING; // R7
				end else if (signon_fail) begin
					state_d = link_pkg::ST_ERROR; // R18
				end else if (signed_on) begin
					state_d = link_pkg::ST_PRE_SESSION; // R9
					phase_d = link_pkg::PH_IDLE;
				end
			end
			link_pkg::ST_PRE_SESSION: begin
				if (power_up) begin
					state_d = link_pkg::ST_CONNECTING; // R17
				end else begin
					case (phase_q) // R10
						link_pkg::PH_IDLE: begin
							if (PRETRANSMIT_CFG) begin
								phase_d = link_pkg::PH_PRETRANSMIT;
							end else if (PREFETCH_CFG) begin
								phase_d = link_pkg::PH_PREFETCH;
							end else begin
								phase_d = link_pkg::PH_DONE;
							end
						end
						link_pkg::PH_PRETRANSMIT: begin
							if (op_fail) begin
								state_d = link_pkg::ST_ERROR;
							end else if (op_done) begin
								phase_d = PREFETCH_CFG ? link_pkg::PH_PREFETCH
									: link_pkg::PH_DONE; // R10
							end
						end
						link_pkg::PH_PREFETCH: begin
							if (op_fail) begin
								state_d = link_pkg::ST_ERROR;
							end else if (op_done) begin
								phase_d = link_pkg::PH_DONE;
							end
						end
						link_pkg::PH_DONE: begin
							state_d = link_pkg::ST_PROGRAM; // R11
						end
						default: begin
							phase_d = link_pkg::PH_IDLE;
						end
					endcase
				end
			end
			link_pkg::ST_PROGRAM: begin
				if (cmd_error) begin
					state_d = link_pkg::ST_ERROR; // R8
				end else if (cmd_disconnect) begin
					state_d = link_pkg::ST_SESSION_CLOSE; // R7
				end else if (cmd_reconnect || auto_rc) begin
					state_d = link_pkg::ST_SESSION_RESTART; // R6
				end else if (!USER_PROGRAM_LOADED || !auto_on || prog_done) begin
					state_d = link_pkg::ST_CONNECTED; // R12
				end
			end
			link_pkg::ST_CONNECTED: begin
				if (cmd_error) begin
					state_d = link_pkg::ST_ERROR; // R8
				end else if (cmd_disconnect) begin
					state_d = link_pkg::ST_SESSION_CLOSE; // R7
				end else if (cmd_reconnect || (auto_on && auto_rc)) begin
					state_d = link_pkg::ST_SESSION_RESTART; // R6
				end else if (power_up) begin
					state_d = link_pkg::ST_CONNECTING; // R17
				end else if (!present) begin
					state_d = link_pkg::ST_ERROR; // R20
				end
			end
			link_pkg::ST_SESSION_RESTART: begin
				if (signoff_fail) begin
					state_d = link_pkg::ST_ERROR; // R19
				end else if (signoff_done) begin
					state_d = link_pkg::ST_CONNECTING; // R16
				end
			end
			link_pkg::ST_SESSION_CLOSE: begin
				if (signoff_fail) begin
					state_d = link_pkg::ST_ERROR; // R19
				end else if (signoff_done) begin
					state_d = link_pkg::ST_DISCONNECTED; // R14
					field_d = 1'b0; // R14
				end
			end
			link_pkg::ST_STOPPING: begin
				state_d = link_pkg::ST_DISCONNECTED; // R15
				field_d = 1'b0; // R15
			end
			default: begin
				state_d = link_pkg::ST_DISCONNECTED;
				field_d = link_pkg::FIELD_RST;
			end
		endcase
		if (state_d == link_pkg::ST_ERROR || state_d == link_pkg::ST_DISCONNECTED) begin
			phase_d = link_pkg::PH_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// reported link state, busy for internal states
	// ----------------------------------------------------------------
	always_comb begin
		case (state_d) // R3
			link_pkg::ST_DISCONNECTED: act_d = link_pkg::ACT_DISCONNECTED;
			link_pkg::ST_CONNECTING:   act_d = link_pkg::ACT_CONNECTING;
			link_pkg::ST_PROGRAM:      act_d = link_pkg::ACT_PROGRAM;
			link_pkg::ST_CONNECTED:    act_d = link_pkg::ACT_CONNECTED;
			link_pkg::ST_ERROR:        act_d = link_pkg::ACT_ERROR;
			default:                   act_d = link_pkg::ACT_BUSY;
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= link_pkg::ST_DISCONNECTED; // R4
			phase_q <= link_pkg::PH_IDLE;
			field_q <= link_pkg::FIELD_RST; // R4
			act_q   <= link_pkg::ACT_DISCONNECTED;
		end else begin
			state_q <= state_d; // R1 R2
			phase_q <= phase_d;
			field_q <= field_d;
			act_q   <= act_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb begin
		RADIO_FIELD_ON    = field_q;
		CHANNEL_CLOSE     = state_q == link_pkg::ST_SESSION_RESTART
			|| state_q == link_pkg::ST_SESSION_CLOSE; // R14 R16
		AWAIT_TAGS        = state_q == link_pkg::ST_CONNECTING; // R15
		PRETRANSMIT_RUN   = state_q == link_pkg::ST_PRE_SESSION
			&& phase_q == link_pkg::PH_PRETRANSMIT;
		PREFETCH_RUN      = state_q == link_pkg::ST_PRE_SESSION
			&& phase_q == link_pkg::PH_PREFETCH;
		USER_ACTIONS_EN   = state_q == link_pkg::ST_PROGRAM
			&& USER_PROGRAM_LOADED && !LEGACY_RELEASE; // R13
		AUTO_MODE_RUN     = state_q == link_pkg::ST_PROGRAM && auto_on;
		ACTUAL_LINK_STATE = act_q;
	end

endmodule : tag_link_state_machine

/* tag_link_state_machine_tb_top.sv */
// self-checking bench for the tag link state machine
// assumes tag_partner on the tag side; the bench acts as fieldbus master
`timescale 1ns/1ps
module tag_link_state_machine_tb_top;
	logic       CLOCK = 1'b0;
	logic       ARST_N, CMD_VALID, AUTO_RECONNECT, PRETRANSMIT_CFG, PREFETCH_CFG;
	logic       USER_PROGRAM_LOADED, AUTO_MODE_ON, LEGACY_RELEASE, TAG_POWER_UP;
	logic       TAG_SIGNED_ON, TAG_SIGNON_FAIL, TAG_SIGNOFF_DONE, TAG_SIGNOFF_FAIL;
	logic       TAG_PRESENT, OP_DONE, RADIO_FIELD_ON, CHANNEL_CLOSE, AWAIT_TAGS;
	logic       PRETRANSMIT_RUN, PREFETCH_RUN, USER_ACTIONS_EN, AUTO_MODE_RUN;
	logic [2:0] CMD_CODE, ACTUAL_LINK_STATE;
	logic       tag_in, slow, bad_on, bad_off;
	logic       OP_FAIL, PROGRAM_DONE;
	int         fail_count, n_tests, cycles;

	tag_link_state_machine uut (.CLOCK, .ARST_N, .CMD_VALID, .CMD_CODE, .AUTO_RECONNECT,
		.PRETRANSMIT_CFG, .PREFETCH_CFG, .USER_PROGRAM_LOADED, .AUTO_MODE_ON, .LEGACY_RELEASE,
		.TAG_SIGNED_ON, .TAG_SIGNON_FAIL, .TAG_SIGNOFF_DONE, .TAG_SIGNOFF_FAIL, .TAG_POWER_UP,
		.TAG_PRESENT, .OP_DONE, .OP_FAIL, .PROGRAM_DONE, .RADIO_FIELD_ON,
		.CHANNEL_CLOSE, .AWAIT_TAGS, .PRETRANSMIT_RUN, .PREFETCH_RUN, .USER_ACTIONS_EN,
		.AUTO_MODE_RUN, .ACTUAL_LINK_STATE);
	tag_partner u_tag (.clk(CLOCK), .arst_n(ARST_N), .tag_in, .slow, .bad_on, .bad_off,
		.field_on(RADIO_FIELD_ON), .await_tags(AWAIT_TAGS), .chan_close(CHANNEL_CLOSE),
		.pretx_run(PRETRANSMIT_RUN), .fetch_run(PREFETCH_RUN), .signed_on(TAG_SIGNED_ON),
		.signon_fail(TAG_SIGNON_FAIL), .signoff_done(TAG_SIGNOFF_DONE),
		.signoff_fail(TAG_SIGNOFF_FAIL), .present(TAG_PRESENT), .op_done(OP_DONE));

	always #25 CLOCK = ~CLOCK;
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("checks %0d failures %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [2:0] seen, input logic [2:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK);
		#2;
	endtask : tick
	task automatic cmd(input logic [2:0] c);
		tick(1);
		CMD_VALID = 1'b1;
		CMD_CODE  = c;
		tick(1);
		CMD_VALID = 1'b0;
	endtask : cmd
	task automatic wait_act(input logic [2:0] exp, input string what);
		for (int i = 0; i < 40 && ACTUAL_LINK_STATE !== exp; i++) tick(1);
		chk(ACTUAL_LINK_STATE, exp, what);
	endtask : wait_act

	task automatic t_power_on;
		chk(ACTUAL_LINK_STATE, link_pkg::ACT_DISCONNECTED, "reset state");
		chk({2'h0, RADIO_FIELD_ON}, 3'h0, "reset field");
		cmd(link_pkg::CMD_RECONNECT);
		cmd(link_pkg::CMD_DISCONNECT);
		tick(4);
		chk(ACTUAL_LINK_STATE, link_pkg::ACT_DISCONNECTED, "illegal cmd");
	endtask : t_power_on
	task automatic t_session;
		{PRETRANSMIT_CFG, PREFETCH_CFG, USER_PROGRAM_LOADED, AUTO_MODE_ON, tag_in} = 5'h1f;
		cmd(link_pkg::CMD_CONNECT);
		chk(ACTUAL_LINK_STATE, link_pkg::ACT_CONNECTING, "connect");
		chk({2'h0, RADIO_FIELD_ON}, 3'h1, "field on");
		chk({2'h0, AWAIT_TAGS}, 3'h1, "await tags");
		wait_act(link_pkg::ACT_PROGRAM, "program");
		chk({2'h0, USER_ACTIONS_EN}, 3'h1, "user on");
		LEGACY_RELEASE = 1'b1;
		tick(1);
		chk({1'b0, USER_ACTIONS_EN, AUTO_MODE_RUN}, 3'h1, "legacy");
		cmd(link_pkg::CMD_RECONNECT);
		chk({1'b0, RADIO_FIELD_ON, CHANNEL_CLOSE}, 3'h3, "field kept");
		wait_act(link_pkg::ACT_CONNECTING, "restart");
		wait_act(link_pkg::ACT_PROGRAM, "resign");
		AUTO_RECONNECT = 1'b1;
		wait_act(link_pkg::ACT_BUSY, "auto restart");
		{AUTO_RECONNECT, AUTO_MODE_ON} = 2'h0;
		wait_act(link_pkg::ACT_CONNECTED, "auto off");
		tick(10);
		chk(ACTUAL_LINK_STATE, link_pkg::ACT_CONNECTED, "stable");
		tag_in = 1'b0;
		wait_act(link_pkg::ACT_ERROR, "tag lost");
		cmd(link_pkg::CMD_CONNECT);
		chk(ACTUAL_LINK_STATE, link_pkg::ACT_CONNECTING, "from error");
		tag_in = 1'b1;
		wait_act(link_pkg::ACT_CONNECTED, "again");
		cmd(link_pkg::CMD_ERROR);
		chk(ACTUAL_LINK_STATE, link_pkg::ACT_ERROR, "error cmd");
		cmd(link_pkg::CMD_DISCONNECT);
		wait_act(link_pkg::ACT_DISCONNECTED, "closed");
	endtask : t_session
	task automatic t_stop;
		tag_in = 1'b0;
		cmd(link_pkg::CMD_CONNECT);
		cmd(link_pkg::CMD_DISCONNECT);
		tick(1);
		chk(ACTUAL_LINK_STATE, link_pkg::ACT_DISCONNECTED, "stopped");
		chk({1'b0, AWAIT_TAGS, RADIO_FIELD_ON}, 3'h0, "stop idle");
	endtask : t_stop
	task automatic t_faults;
		{tag_in, bad_on} = 2'h3;
		cmd(link_pkg::CMD_CONNECT);
		wait_act(link_pkg::ACT_ERROR, "signon fail");
		{bad_on, bad_off} = 2'h1;
		cmd(link_pkg::CMD_DISCONNECT);
		wait_act(link_pkg::ACT_ERROR, "signoff fail");
		bad_off = 1'b0;
		cmd(link_pkg::CMD_DISCONNECT);
		wait_act(link_pkg::ACT_DISCONNECTED, "recovered");
	endtask : t_faults
	task automatic t_power_up;
		{slow, PRETRANSMIT_CFG, PREFETCH_CFG} = 3'h4;
		cmd(link_pkg::CMD_CONNECT);
		wait_act(link_pkg::ACT_CONNECTED, "no cfg");
		TAG_POWER_UP = 1'b1;
		tick(4);
		TAG_POWER_UP = 1'b0;
		wait_act(link_pkg::ACT_CONNECTING, "power up");
		cmd(link_pkg::CMD_DISCONNECT);
		wait_act(link_pkg::ACT_DISCONNECTED, "end");
	endtask : t_power_up
	task automatic t_op_fail;
		{slow, PRETRANSMIT_CFG, AUTO_MODE_ON} = 3'h3;
		cmd(link_pkg::CMD_CONNECT);
		wait_act(link_pkg::ACT_BUSY, "pre-session");
		tick(1);
		chk({2'h0, PRETRANSMIT_RUN}, 3'h1, "pretransmit run");
		OP_FAIL = 1'b1;
		wait_act(link_pkg::ACT_ERROR, "op fail");
		OP_FAIL = 1'b0;
		cmd(link_pkg::CMD_CONNECT);
		wait_act(link_pkg::ACT_PROGRAM, "program held");
		tick(4);
		chk(ACTUAL_LINK_STATE, link_pkg::ACT_PROGRAM, "auto mode stays");
		PROGRAM_DONE = 1'b1;
		wait_act(link_pkg::ACT_CONNECTED, "program done");
		PROGRAM_DONE = 1'b0;
		cmd(link_pkg::CMD_DISCONNECT);
		wait_act(link_pkg::ACT_DISCONNECTED, "ops end");
	endtask : t_op_fail

	initial begin
		{ARST_N, CMD_VALID, CMD_CODE, AUTO_RECONNECT, PRETRANSMIT_CFG, PREFETCH_CFG} = 8'h0;
		{USER_PROGRAM_LOADED, AUTO_MODE_ON, LEGACY_RELEASE, TAG_POWER_UP} = 4'h0;
		{OP_FAIL, PROGRAM_DONE} = 2'h0;
		{tag_in, slow, bad_on, bad_off} = 4'h0;
		fail_count = 0;
		n_tests = 0;
		cycles = 0;
		repeat (5) @(posedge CLOCK);
		#2 ARST_N = 1'b1;
		t_power_on();
		t_session();
		t_stop();
		t_faults();
		t_power_up();
		t_op_fail();
		print_verdict();
	end
endmodule : tag_link_state_machine_tb_top

/* tag_partner.sv */
// model of the mobile data tag and the pre-session operation engine
// assumes the head's CLOCK; event lines idle low
`timescale 1ns/1ps
module tag_partner (
	// clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// bench controls
	input  wire logic tag_in,
	input  wire logic slow,
	input  wire logic bad_on,
	input  wire logic bad_off,
	// head outputs
	input  wire logic field_on,
	input  wire logic await_tags,
	input  wire logic chan_close,
	input  wire logic pretx_run,
	input  wire logic fetch_run,
	// tag events
	output logic      signed_on,
	output logic      signon_fail,
	output logic      signoff_done,
	output logic      signoff_fail,
	output logic      present,
	output logic      op_done
);
	logic [3:0] cnt_q, cnt_d, seen_q, seen_d, dly;
	logic       ripe;
	// delay restarts whenever the head's activity changes
	always_comb begin
		seen_d = {await_tags, chan_close, pretx_run, fetch_run};
		cnt_d  = (seen_d != seen_q) ? 4'h0 : ((cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1);
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q  <= 4'h0;
			seen_q <= 4'h0;
		end else begin
			cnt_q  <= cnt_d;
			seen_q <= seen_d;
		end
	end
	assign dly          = slow ? 4'h8 : 4'h2;
	assign ripe         = cnt_q >= dly;
	assign present      = tag_in;
	assign signed_on    = await_tags && field_on && tag_in && !bad_on && ripe;
	assign signon_fail  = await_tags && field_on && tag_in && bad_on && ripe;
	assign signoff_done = chan_close && !bad_off && ripe;
	assign signoff_fail = chan_close && bad_off && ripe;
	// one pulse per operation
	assign op_done      = (pretx_run || fetch_run) && cnt_q == dly;
endmodule : tag_partner
